/* File: rtl/psm_defines.svh */
// Register indices, field positions, cause codes and reset values
`ifndef PSM_DEFINES_SVH
`define PSM_DEFINES_SVH
`define PSM_IDX_MASTER   8'h30
`define PSM_IDX_IDLE     8'h31
`define PSM_IDX_INPSEL   8'h32
`define PSM_IDX_TRIGEN   8'h33
`define PSM_IDX_TRAPEN   8'h34
`define PSM_IDX_ROUTE    8'h35
`define PSM_IDX_IRQLO    8'h36
`define PSM_IDX_IRQHI    8'h37
`define PSM_IDX_DRQ      8'h38
`define PSM_IDX_RANGE    8'h3C
`define PSM_IDX_RESUME   8'h3D
`define PSM_IDX_SHADOW   8'h3F
`define PSM_IDX_PWRCTL   8'h40
`define PSM_IDX_PWRDATA  8'h41
`define PSM_IDX_MEMLO    8'h25
`define PSM_IDX_MEMHI    8'h26
`define PSM_IDX_MEMMSK   8'h27
`define PSM_IDX_RTCPORT  8'h70
`define PSM_MST_UNIT_EN  2
`define PSM_MST_SMI_EN   4
`define PSM_MST_SW_STOP  5
`define PSM_MST_NODRQREL 6
`define PSM_MST_NOIRQREL 7
`define PSM_INP_THROTTLE 4
`define PSM_INP_IRQSEL   7
`define PSM_TRG_RTC      3
`define PSM_TRG_INPUT    4
`define PSM_TRG_IRQ      5
`define PSM_TRG_DRQ      6
`define PSM_TRG_SUSPEND  7
`define PSM_RES_PREP     2
`define PSM_PWC_LEVEL    0
`define PSM_PWC_LATCH    2
`define PSM_CAUSE_RTC    4'h4
`define PSM_CAUSE_INPUT  4'h5
`define PSM_CAUSE_IRQ    4'h6
`define PSM_CAUSE_DRQ    4'h7
`define PSM_CAUSE_SUSP   4'h8
`define PSM_CAUSE_TRAP0  4'h9
`define PSM_RST_REG      8'h00
`define PSM_RST_PWRCTL   8'h01
`endif

/* File: rtl/psm_pkg.sv */
// Types shared by the power-management event block
package psm_pkg;
    typedef enum logic [1:0] {
        PSM_ROUTE_SMI  = 2'b00,
        PSM_ROUTE_NMI  = 2'b01,
        PSM_ROUTE_IRQ15 = 2'b10,
        PSM_ROUTE_IRQ10 = 2'b11
    } psm_route_t;
    typedef enum logic [0:0] {
        PSM_STOP_IDLE = 1'b0,
        PSM_STOP_HALT = 1'b1
    } psm_stop_t;
endpackage

/* File: rtl/psm_sync.sv */
// Two-flop synchroniser bank for pin inputs
`timescale 1ns/1ps
module psm_sync #(
    parameter int W = 8
) (
    // Clock and reset
    input  wire logic         mclk,
    input  wire logic         rst,
    // Data
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] stage1;

    // First stage feeds only the second
    always_ff @(posedge mclk) begin
        if (rst) begin
            stage1 <= '0;
            dout   <= '0;
        end else begin
            stage1 <= din;
            dout   <= stage1;
        end
    end
endmodule // psm_sync

/* File: rtl/psm_pmu.sv */
// Power-management trigger, trap, stop-clock and power-strobe logic
//
// How it works
// - Five activity triggers feed the interrupt.
// - Unit enable gates every power event.
// - Global enable; zero write drops interrupt.
// - Selected IRQ activity raises cause 6.
// - Selected DRQ activity raises cause 7.
// - Selected input device access raises cause 5.
// - RTC alarm raises cause 4.
// - Suspend button, chosen polarity, raises cause 8.
// - Cause code readable in low nibble.
// - Zero write to trigger enable drops pending.
// - Five trap events give causes 9 to D.
// - Zero write to trap enable drops trap.
// - Trap ranges decoded from range registers.
// - Resume-prepare bit pulses chip resume.
// - Shadow of last RTC index port write.
// - Software stop request self-clears on release.
// - Any interrupt event releases stop-clock.
// - IRQ/NMI release unless blocked, per select.
// - DRQ/master requests release unless blocked.
// - Idle timeout asserts stop when throttling.
// - Latched mode: power bits follow data, strobe pulses low.
// - Level mode: strobe follows level bit.
// - Route select chooses interrupt delivery pin.
//
// The Wishbone interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`include "psm_defines.svh"
module psm_pmu (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rst,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [9:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Activity pins, asynchronous
    input  wire logic [15:0] irqActive,
    input  wire logic [7:0]  drqActive,
    input  wire logic        nmiActive,
    input  wire logic        masterReq,
    input  wire logic        rtcAlarm,
    input  wire logic        suspendButtonInput,
    input  wire logic        idleTimeout,
    // Host access snoop, same clock
    input  wire logic        ioWrite,
    input  wire logic        accessValid,
    input  wire logic        accessIsMem,
    input  wire logic [15:0] accessAddr,
    input  wire logic [7:0]  accessData,
    input  wire logic        hardDiskAccess,
    input  wire logic        printerPortAccess,
    input  wire logic [2:0]  inputDevAccess,
    // Processor side
    output logic             smiOut,
    output logic             nmiOut,
    output logic             irq15Out,
    output logic             irq10Out,
    output logic             cpuClockHaltReq,
    output logic             resumePrep,
    // Power-control outputs
    output logic [7:0]       dramAddrLinesLow,
    output logic             powerStrobeOut
);
    ////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic [15:0] irqS;
    logic [7:0]  drqS;
    logic [4:0]  miscS;
    logic        nmiS, masterS, rtcS, suspS, idleS;

    psm_sync #(.W(16)) uSyncIrq (
        .mclk (mclk),
        .rst  (rst),
        .din  (irqActive),
        .dout (irqS)
    );
    psm_sync #(.W(8)) uSyncDrq (
        .mclk (mclk),
        .rst  (rst),
        .din  (drqActive),
        .dout (drqS)
    );
    psm_sync #(.W(5)) uSyncMisc (
        .mclk (mclk),
        .rst  (rst),
        .din  ({nmiActive, masterReq, rtcAlarm, suspendButtonInput,
                idleTimeout}),
        .dout (miscS)
    );
    assign {nmiS, masterS, rtcS, suspS, idleS} = miscS;

    ////////////////////////////////////////////////////////////////////
    // Register bus: index is word address, one-cycle ack
    logic [7:0] idx;
    logic       req, wr, rdHit;
    assign idx = wb_adr_i[9:2];
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr  = req && wb_we_i && wb_sel_i[0];

    function automatic logic wrAt(input logic [7:0] i);
        return wr && (idx == i);
    endfunction

    logic [7:0] regMaster, regIdle, regInpSel, regTrigEn, regTrapEn;
    logic [7:0] regRoute, regIrqLo, regIrqHi, regDrq, regRange;
    logic [7:0] regResume, regShadow, regPwrCtl, regPwrData;
    logic [7:0] regMemLo, regMemHi, regMemMsk;
    logic [3:0] cause;
    logic       stopRel;

    // Ack pulses one cycle, drops in the next
    always_ff @(posedge mclk) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= req;
        end
    end

    // Plain configuration registers
    always_ff @(posedge mclk) begin
        if (rst) begin
            regIdle    <= `PSM_RST_REG;
            regInpSel  <= `PSM_RST_REG;
            regRoute   <= `PSM_RST_REG;
            regIrqLo   <= `PSM_RST_REG;
            regIrqHi   <= `PSM_RST_REG;
            regDrq     <= `PSM_RST_REG;
            regRange   <= `PSM_RST_REG;
            regPwrCtl  <= `PSM_RST_PWRCTL;
            regPwrData <= `PSM_RST_REG;
            regMemLo   <= `PSM_RST_REG;
            regMemHi   <= `PSM_RST_REG;
            regMemMsk  <= `PSM_RST_REG;
        end else begin
            if (wrAt(`PSM_IDX_IDLE))    regIdle    <= wb_dat_i[7:0];
            if (wrAt(`PSM_IDX_INPSEL))  regInpSel  <= wb_dat_i[7:0];
            if (wrAt(`PSM_IDX_ROUTE))   regRoute   <= wb_dat_i[7:0];
            if (wrAt(`PSM_IDX_IRQLO))   regIrqLo   <= wb_dat_i[7:0];
            if (wrAt(`PSM_IDX_IRQHI))   regIrqHi   <= wb_dat_i[7:0];
            if (wrAt(`PSM_IDX_DRQ))     regDrq     <= wb_dat_i[7:0];
            if (wrAt(`PSM_IDX_RANGE))   regRange   <= wb_dat_i[7:0];
            if (wrAt(`PSM_IDX_PWRCTL))  regPwrCtl  <= wb_dat_i[7:0];
            if (wrAt(`PSM_IDX_PWRDATA)) regPwrData <= wb_dat_i[7:0];
            if (wrAt(`PSM_IDX_MEMLO))   regMemLo   <= wb_dat_i[7:0];
            if (wrAt(`PSM_IDX_MEMHI))   regMemHi   <= wb_dat_i[7:0];
            if (wrAt(`PSM_IDX_MEMMSK))  regMemMsk  <= wb_dat_i[7:0];
        end
    end

    // Enable registers; pending events live beside them
    always_ff @(posedge mclk) begin
        if (rst) begin
            regTrigEn <= `PSM_RST_REG;
            regTrapEn <= `PSM_RST_REG;
        end else begin
            if (wrAt(`PSM_IDX_TRIGEN)) regTrigEn <= wb_dat_i[7:0];
            if (wrAt(`PSM_IDX_TRAPEN)) regTrapEn <= wb_dat_i[7:0];
        end
    end

    // Master control; software stop bit clears on release
    always_ff @(posedge mclk) begin
        if (rst) begin
            regMaster <= `PSM_RST_REG;
        end else if (wrAt(`PSM_IDX_MASTER)) begin
            regMaster <= wb_dat_i[7:0];
        end else if (stopRel) begin
            regMaster[`PSM_MST_SW_STOP] <= 1'b0;
        end
    end

    // Resume-prepare bit strobes out and reads back zero
    always_ff @(posedge mclk) begin
        if (rst) begin
            regResume  <= `PSM_RST_REG;
            resumePrep <= 1'b0;
        end else begin
            resumePrep <= wrAt(`PSM_IDX_RESUME)
                          && wb_dat_i[`PSM_RES_PREP];
            if (wrAt(`PSM_IDX_RESUME)) begin
                regResume <= wb_dat_i[7:0] & 8'hFB;
            end
        end
    end

    // Shadow of host writes to the RTC index port
    always_ff @(posedge mclk) begin
        if (rst) begin
            regShadow <= `PSM_RST_REG;
        end else if (accessValid && !accessIsMem && ioWrite
                     && accessAddr == {8'h00, `PSM_IDX_RTCPORT}) begin
            regShadow <= accessData;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Event detection
    logic unitEn;
    assign unitEn = regMaster[`PSM_MST_UNIT_EN];

    logic [15:0] irqSel;
    logic        irqHit, drqHit, inputHit, suspHit;
    assign irqSel   = {regIrqHi, regIrqLo};
    assign irqHit   = |(irqS & irqSel);
    assign drqHit   = |(drqS & regDrq);
    assign inputHit = |(inputDevAccess & regInpSel[7:5]);
    // Polarity 00 high, 01 low, 1x either level seen as change
    logic suspPrev;
    always_ff @(posedge mclk) begin
        if (rst) begin
            suspPrev <= 1'b0;
        end else begin
            suspPrev <= suspS;
        end
    end
    always_comb begin
        unique case (regTrapEn[6:5])
            2'b00:   suspHit = suspS;
            2'b01:   suspHit = !suspS;
            default: suspHit = suspS ^ suspPrev;
        endcase
    end

    // Trap range decode: VGA window, general I/O block, memory window
    logic vgaHit, ioHit, memHit;
    always_comb begin
        unique case (regRange[1:0])
            2'b00: vgaHit = accessAddr[15:4] == 12'h03B
                            || accessAddr[15:4] == 12'h03C
                            || accessAddr[15:4] == 12'h03D;
            2'b01: vgaHit = accessAddr[15:4] == 12'h03B;
            2'b10: vgaHit = accessAddr[15:4] == 12'h03C;
            2'b11: vgaHit = accessAddr[15:4] == 12'h03D;
        endcase
        vgaHit = vgaHit && accessValid && !accessIsMem;
    end
    assign ioHit  = accessValid && !accessIsMem && regRange[4:2] != 3'h0
                    && accessAddr[15:7] == {6'h00, regRange[4:2]};
    assign memHit = accessValid && accessIsMem
                    && ((accessAddr ^ {regMemHi, regMemLo})
                        & ~{regMemMsk, 8'h00}) == 16'h0000;

    logic [4:0] trapHit;
    assign trapHit = {memHit, ioHit, printerPortAccess && accessValid,
                      hardDiskAccess && accessValid, vgaHit};

    logic [4:0] trigHit;
    assign trigHit = {suspHit & regTrigEn[`PSM_TRG_SUSPEND],
                      drqHit  & regTrigEn[`PSM_TRG_DRQ],
                      irqHit  & regTrigEn[`PSM_TRG_IRQ],
                      inputHit & regTrigEn[`PSM_TRG_INPUT],
                      rtcS    & regTrigEn[`PSM_TRG_RTC]};

    ////////////////////////////////////////////////////////////////////
    // Pending flags: set wins over a zero write to the enable
    logic [4:0] trigPend, trapPend;
    logic [4:0] trigKeep, trapKeep;
    assign trigKeep = ~{5{wrAt(`PSM_IDX_TRIGEN)}} | wb_dat_i[7:3];
    assign trapKeep = ~{5{wrAt(`PSM_IDX_TRAPEN)}} | wb_dat_i[4:0];
    always_ff @(posedge mclk) begin
        if (rst) begin
            trigPend <= 5'h00;
            trapPend <= 5'h00;
        end else begin
            trigPend <= (trigPend & trigKeep & {5{unitEn}})
                        | (trigHit & {5{unitEn}});
            trapPend <= (trapPend & trapKeep & {5{unitEn}})
                        | (trapHit & regTrapEn[4:0]
                           & {5{unitEn}});
        end
    end

    // Cause code of the lowest-numbered pending event
    function automatic logic [3:0] causeOf(input logic [4:0] tg,
                                            input logic [4:0] tp);
        logic [3:0] c;
        c = 4'h0;
        for (int i = 4; i >= 0; i--) begin
            if (tp[i]) c = `PSM_CAUSE_TRAP0 + 4'(i);
        end
        for (int i = 4; i >= 0; i--) begin
            if (tg[i]) c = `PSM_CAUSE_RTC + 4'(i);
        end
        return c;
    endfunction

    logic anyPend, anyNew;
    assign anyPend = |trigPend || |trapPend;
    assign anyNew  = unitEn && (|trigHit || |(trapHit & regTrapEn[4:0]));

    // Cause latch and interrupt line, held until enable is cleared
    logic smiLvl;
    always_ff @(posedge mclk) begin
        if (rst) begin
            smiLvl <= 1'b0;
            cause  <= 4'h0;
        end else if (!regMaster[`PSM_MST_SMI_EN]) begin
            smiLvl <= 1'b0;
        end else if (!smiLvl && anyPend) begin
            smiLvl <= 1'b1;
            cause  <= causeOf(trigPend, trapPend);
        end
    end

    // Route onto the selected processor pin
    psm_pkg::psm_route_t route;
    assign route = psm_pkg::psm_route_t'(regRoute[5:4]);
    always_ff @(posedge mclk) begin
        if (rst) begin
            smiOut   <= 1'b0;
            nmiOut   <= 1'b0;
            irq15Out <= 1'b0;
            irq10Out <= 1'b0;
        end else begin
            smiOut   <= smiLvl && route == psm_pkg::PSM_ROUTE_SMI;
            nmiOut   <= smiLvl && route == psm_pkg::PSM_ROUTE_NMI;
            irq15Out <= smiLvl && route == psm_pkg::PSM_ROUTE_IRQ15;
            irq10Out <= smiLvl && route == psm_pkg::PSM_ROUTE_IRQ10;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Stop-clock request
    logic irqRel, drqRel;
    assign irqRel = !regMaster[`PSM_MST_NOIRQREL]
                    && (nmiS || (!regInpSel[`PSM_INP_IRQSEL]
                                 && |(irqS & irqSel)));
    assign drqRel = !regMaster[`PSM_MST_NODRQREL]
                    && (|drqS || masterS);
    // An interrupt event releases unconditionally
    assign stopRel = cpuClockHaltReq
                     && (anyNew || smiLvl || irqRel || drqRel);

    psm_pkg::psm_stop_t stopState;
    logic throttleGo;
    // No throttling while an interrupt stands
    assign throttleGo = unitEn && regInpSel[`PSM_INP_THROTTLE]
                        && idleS && !smiLvl;
    always_ff @(posedge mclk) begin
        if (rst) begin
            stopState <= psm_pkg::PSM_STOP_IDLE;
        end else begin
            unique case (stopState)
                psm_pkg::PSM_STOP_IDLE:
                    if ((regMaster[`PSM_MST_SW_STOP] || throttleGo)
                        && !stopRel && !anyNew) begin
                        stopState <= psm_pkg::PSM_STOP_HALT;
                    end
                psm_pkg::PSM_STOP_HALT:
                    if (stopRel) begin
                        stopState <= psm_pkg::PSM_STOP_IDLE;
                    end
            endcase
        end
    end
    assign cpuClockHaltReq = stopState == psm_pkg::PSM_STOP_HALT;

    ////////////////////////////////////////////////////////////////////
    // Power-control outputs
    logic pwcLatchWr;
    assign pwcLatchWr = wrAt(`PSM_IDX_PWRCTL) && regPwrCtl[`PSM_PWC_LATCH]
                        && !wb_dat_i[`PSM_PWC_LEVEL];
    always_ff @(posedge mclk) begin
        if (rst) begin
            dramAddrLinesLow <= 8'h00;
            powerStrobeOut   <= 1'b1;
        end else if (regPwrCtl[`PSM_PWC_LATCH]) begin
            dramAddrLinesLow <= regPwrData;
            powerStrobeOut   <= !pwcLatchWr;
        end else begin
            powerStrobeOut   <= regPwrCtl[`PSM_PWC_LEVEL];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read mux, unmapped indices read zero
    logic [7:0] rdData;
    always_comb begin
        rdHit  = 1'b1;
        unique case (idx)
            `PSM_IDX_MASTER:  rdData = regMaster;
            `PSM_IDX_IDLE:    rdData = regIdle;
            `PSM_IDX_INPSEL:  rdData = regInpSel;
            `PSM_IDX_TRIGEN:  rdData = regTrigEn;
            `PSM_IDX_TRAPEN:  rdData = regTrapEn;
            `PSM_IDX_ROUTE:   rdData = {regRoute[7:4], cause};
            `PSM_IDX_IRQLO:   rdData = regIrqLo;
            `PSM_IDX_IRQHI:   rdData = regIrqHi;
            `PSM_IDX_DRQ:     rdData = regDrq;
            `PSM_IDX_RANGE:   rdData = regRange;
            `PSM_IDX_RESUME:  rdData = regResume;
            `PSM_IDX_SHADOW:  rdData = regShadow;
            `PSM_IDX_PWRCTL:  rdData = regPwrCtl;
            `PSM_IDX_PWRDATA: rdData = regPwrData;
            `PSM_IDX_MEMLO:   rdData = regMemLo;
            `PSM_IDX_MEMHI:   rdData = regMemHi;
            `PSM_IDX_MEMMSK:  rdData = regMemMsk;
            default: begin
                rdData = 8'h00;
                rdHit  = 1'b0;
            end
        endcase
    end
    always_ff @(posedge mclk) begin
        if (rst) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (req && !wb_we_i && rdHit) begin
            wb_dat_o <= {24'h000000, rdData};
        end else begin
            wb_dat_o <= 32'h0000_0000;
        end
    end
endmodule // psm_pmu

/* File: bench/psm_pmu_asserts.sv */
// Port-level checks for the event block
`timescale 1ns/1ps
module psm_pmu_asserts (
    // Clock and reset
    input wire logic        mclk,
    input wire logic        rst,
    // Bus
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_ack_o,
    input wire logic [31:0] wb_dat_o,
    // Processor and power side
    input wire logic        smiOut,
    input wire logic        nmiOut,
    input wire logic        irq15Out,
    input wire logic        irq10Out,
    input wire logic        cpuClockHaltReq,
    input wire logic        resumePrep,
    input wire logic        powerStrobeOut
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);
    //////////////////////////////////////////////////////////
    // Delivery pins
    wire [3:0] pins = {irq10Out, irq15Out, nmiOut, smiOut};
    // Request taken, then a single-cycle answer
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_ans;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    chk_ack_answer: assert property (s_req |=> s_ans)
        else $error("ack not one cycle");
    chk_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without a request");
    chk_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("data outside ack");
    chk_dat_upper: assert property (wb_dat_o[31:8] == 24'h0)
        else $error("upper data set");
    chk_route_single: assert property ($onehot0(pins))
        else $error("two delivery pins");
    chk_resume_pulse: assert property ($rose(resumePrep) |=> !resumePrep)
        else $error("resume pulse too long");
    chk_reset_state: assert property ($fell(rst) |->
        powerStrobeOut && pins == 4'h0 && !cpuClockHaltReq)
        else $error("bad reset outputs");
    chk_smi_release: assert property ($rose(|pins) |-> ##[0:2] !cpuClockHaltReq)
        else $error("stop not released");
endmodule // psm_pmu_asserts

/* File: bench/psm_cpu_model.sv */
// Host processor stand-in
`timescale 1ns/1ps
module psm_cpu_model (
    // Clock and reset
    input  wire logic       mclk,
    input  wire logic       rst,
    // Requests from the block
    input  wire logic       smiOut,
    input  wire logic       cpuClockHaltReq,
    // Observed state
    output logic      [7:0] smiCount,
    output logic            halted
);
    logic smiLast;
    //////////////////////////////////////////////////////////
    // Count rising requests only
    always_ff @(posedge mclk) begin
        smiLast <= rst ? 1'b0 : smiOut;
        if (rst)
            smiCount <= 8'h00;
        else if (smiOut && !smiLast)
            smiCount <= smiCount + 8'h01;
    end
    // Halted while requested
    always_ff @(posedge mclk)
        halted <= !rst && cpuClockHaltReq;
endmodule // psm_cpu_model

/* File: bench/tb.sv */
// Self-checking bench for the event block
`timescale 1ns/1ps
`include "psm_defines.svh"
module tb;
    logic        mclk, rst, cyc, stb, we, ack;
    logic [3:0]  sel;
    logic [9:0]  adr;
    logic [31:0] datI, datO;
    logic [15:0] irqA, aAddr;
    logic [7:0]  drqA, aData, dram, smiCount;
    logic [2:0]  inDev;
    logic        rtc, susp, idle, ioWr, aVal, disk;
    logic        smi, nmi, i15, i10, halt, resP, strobe, halted;
    wire  [3:0]  pins = {i10, i15, nmi, smi};
    logic [31:0] failures, comparisons, cycles;
    logic [7:0]  en [6] = '{8'h20, 8'h40, 8'h10, 8'h08, 8'h80, 8'h02};
    logic [3:0]  cause [6] = '{4'h6, 4'h7, 4'h5, 4'h4, 4'h8, 4'hA};
    //////////////////////////////////////////////////////////
    psm_pmu dut (.mclk, .rst, .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datI),
        .wb_dat_o(datO), .wb_ack_o(ack), .irqActive(irqA),
        .drqActive(drqA), .nmiActive(1'b0), .masterReq(1'b0),
        .rtcAlarm(rtc), .suspendButtonInput(susp), .idleTimeout(idle),
        .ioWrite(ioWr), .accessValid(aVal), .accessIsMem(1'b0),
        .accessAddr(aAddr), .accessData(aData), .hardDiskAccess(disk),
        .printerPortAccess(1'b0), .inputDevAccess(inDev), .smiOut(smi),
        .nmiOut(nmi), .irq15Out(i15), .irq10Out(i10),
        .cpuClockHaltReq(halt), .resumePrep(resP),
        .dramAddrLinesLow(dram), .powerStrobeOut(strobe));
    psm_cpu_model cpu (.mclk, .rst, .smiOut(smi),
        .cpuClockHaltReq(halt), .smiCount, .halted);
    // 20 MHz clock
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    // Hang guard
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures = failures + 1;
            wrap_up();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons = comparisons + 1;
        if (seen !== exp) begin
            failures = failures + 1;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Classic cycle, held until ack
    task automatic wbx(input logic w, input logic [7:0] idx,
                       input logic [7:0] d, output logic [7:0] q);
        @(posedge mclk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        sel <= 4'h1;
        adr <= {idx, 2'b00};
        datI <= {24'h0, d};
        do @(posedge mclk); while (ack !== 1'b1);
        q = datO[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [7:0] q;
        wbx(1'b1, idx, d, q);
    endtask
    task automatic rd(input logic [7:0] idx, output logic [7:0] q);
        wbx(1'b0, idx, 8'h00, q);
    endtask
    // Counts pulse cycles
    task automatic pulses(input logic s, output logic [31:0] n);
        n = 0;
        repeat (6) begin
            n = n + (s ? (resP === 1'b1) : (strobe === 1'b0));
            @(posedge mclk);
        end
    endtask
    task automatic test_regs();
        logic [7:0]  q;
        logic [31:0] n;
        rd(`PSM_IDX_PWRCTL, q);
        check(q, `PSM_RST_PWRCTL);
        wr(8'h3E, 8'hFF);
        rd(8'h3E, q);
        check(q, 8'h00);
        ioWr <= 1'b1;
        aVal <= 1'b1;
        aAddr <= 16'h0070;
        aData <= 8'h3A;
        @(posedge mclk);
        ioWr <= 1'b0;
        aVal <= 1'b0;
        rd(`PSM_IDX_SHADOW, q);
        check(q, 8'h3A);
        wr(`PSM_IDX_RESUME, 8'h04);
        pulses(1'b1, n);
        check(n, 1);
    endtask
    task automatic drive(input int i, input logic v);
        case (i)
            0: irqA <= {16{v}};
            1: drqA <= {8{v}};
            2: inDev <= {3{v}};
            3: rtc <= v;
            4: susp <= v;
            default: {disk, aVal} <= {2{v}};
        endcase
    endtask
    // Triggers and one trap, route rotating
    task automatic test_triggers();
        logic [7:0] q, idx;
        wr(`PSM_IDX_MASTER, 8'h10);
        wr(`PSM_IDX_TRIGEN, 8'h08);
        drive(3, 1'b1);
        repeat (8) @(posedge mclk);
        check(pins, 4'h0);
        drive(3, 1'b0);
        wr(`PSM_IDX_TRIGEN, 8'h00);
        wr(`PSM_IDX_IRQLO, 8'hFF);
        wr(`PSM_IDX_IRQHI, 8'hFF);
        wr(`PSM_IDX_DRQ, 8'hFF);
        wr(`PSM_IDX_INPSEL, 8'hE0);
        for (int i = 0; i < 6; i++) begin
            idx = (i < 5) ? `PSM_IDX_TRIGEN : `PSM_IDX_TRAPEN;
            wr(`PSM_IDX_ROUTE, 8'((i % 4) << 4));
            wr(idx, en[i]);
            wr(`PSM_IDX_MASTER, 8'h14);
            drive(i, 1'b1);
            repeat (8) @(posedge mclk);
            drive(i, 1'b0);
            rd(`PSM_IDX_ROUTE, q);
            check(q[3:0], cause[i]);
            check(pins, 4'h1 << (i % 4));
            wr(`PSM_IDX_MASTER, 8'h04);
            repeat (4) @(posedge mclk);
            check(pins, 4'h0);
            wr(idx, 8'h00);
            wr(`PSM_IDX_MASTER, 8'h14);
            repeat (6) @(posedge mclk);
            check(pins, 4'h0);
        end
    endtask
    // Stop request and its release paths
    task automatic test_stop();
        logic [7:0] q;
        wr(`PSM_IDX_ROUTE, 8'h00);
        wr(`PSM_IDX_MASTER, 8'h24);
        repeat (3) @(posedge mclk);
        check(halted, 1'b1);
        rd(`PSM_IDX_MASTER, q);
        check(q[5], 1'b1);
        drqA <= 8'hFF;
        repeat (6) @(posedge mclk);
        check(halt, 1'b0);
        drqA <= 8'h00;
        rd(`PSM_IDX_MASTER, q);
        check(q[5], 1'b0);
        wr(`PSM_IDX_MASTER, 8'h64);
        drqA <= 8'hFF;
        repeat (8) @(posedge mclk);
        check(halt, 1'b1);
        drqA <= 8'h00;
        wr(`PSM_IDX_TRIGEN, 8'h08);
        wr(`PSM_IDX_MASTER, 8'h74);
        rtc <= 1'b1;
        repeat (8) @(posedge mclk);
        check(halt, 1'b0);
        rtc <= 1'b0;
        wr(`PSM_IDX_MASTER, 8'h04);
        wr(`PSM_IDX_TRIGEN, 8'h00);
        wr(`PSM_IDX_INPSEL, 8'h10);
        idle <= 1'b1;
        repeat (5) @(posedge mclk);
        idle <= 1'b0;
        check(halt, 1'b1);
        irqA <= 16'hFFFF;
        repeat (6) @(posedge mclk);
        check(halt, 1'b0);
        irqA <= 16'h0000;
    endtask
    // Latched pulse, then level mode
    task automatic test_power();
        logic [31:0] n;
        wr(`PSM_IDX_PWRCTL, 8'h05);
        wr(`PSM_IDX_PWRDATA, 8'hA5);
        repeat (2) @(posedge mclk);
        check(dram, 8'hA5);
        wr(`PSM_IDX_PWRCTL, 8'h04);
        pulses(1'b0, n);
        check(n, 1);
        wr(`PSM_IDX_PWRCTL, 8'h00);
        repeat (2) @(posedge mclk);
        check(strobe, 1'b0);
        wr(`PSM_IDX_PWRCTL, 8'h01);
        repeat (2) @(posedge mclk);
        check(strobe, 1'b1);
    endtask
    task automatic wrap_up();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // Main sequence
    initial begin
        {cyc, stb, we, sel, adr, datI, irqA, drqA, inDev} = '0;
        {rtc, susp, idle, ioWr, aVal, disk, aAddr, aData} = '0;
        {failures, comparisons, cycles} = '0;
        rst = 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        test_regs();
        test_triggers();
        test_stop();
        test_power();
        check(smiCount, 8'h03);
        wrap_up();
    end
endmodule // tb
bind psm_pmu psm_pmu_asserts chk (.mclk, .rst, .wb_cyc_i, .wb_stb_i,
    .wb_ack_o, .wb_dat_o, .smiOut, .nmiOut, .irq15Out, .irq10Out,
    .cpuClockHaltReq, .resumePrep, .powerStrobeOut);
